// File: hdl/timer_port_map.svh
`ifndef TIMER_PORT_MAP_SVH
`define TIMER_PORT_MAP_SVH

`define SETUP_PORT_SEL     2'h3
`define SEL_MSB            7
`define SEL_LSB            6
`define FMT_MSB            5
`define FMT_LSB            4
`define MODE_MSB           3
`define MODE_LSB           1
`define BCD_BIT            0
`define READBACK_SEL       2'h3
`define FMT_LATCH          2'h0
`define FMT_LOW            2'h1
`define FMT_HIGH           2'h2
`define FMT_BOTH           2'h3

`endif

// File: hdl/timer_port_pkg.sv
package timer_port_pkg;
	typedef enum logic [1:0] {
		FORMAT_LATCH,
		FORMAT_LOW,
		FORMAT_HIGH,
		FORMAT_BOTH
	} byte_format_t;

	typedef enum logic [2:0] {
		WAVE_MODE0,
		WAVE_MODE1,
		WAVE_MODE2,
		WAVE_MODE3,
		WAVE_MODE4,
		WAVE_MODE5
	} wave_mode_t;
endpackage : timer_port_pkg

// File: hdl/count_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_port_map.svh"

// One channel: staging register, counting element and output latch.
module count_channel #(
	parameter int COUNT_W = 16
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               ce,
	input  wire logic               setup_wr,
	input  wire logic               latch_cmd,
	input  wire logic [7:0]         setup_byte,
	input  wire logic               data_wr,
	input  wire logic               data_rd,
	input  wire logic [7:0]         wr_byte,
	input  wire logic               count_tick,
	output logic [7:0]              rd_byte,
	output logic [COUNT_W-1:0]      count_value,
	output timer_port_pkg::byte_format_t format,
	output timer_port_pkg::wave_mode_t   mode,
	output logic                    bcd,
	output logic                    loaded
);
	// Refuse widths the four-decade decrement and byte split cannot serve
	if (COUNT_W != 16) begin : g_bad_width
		$error("count_channel serves 16-bit counts only");
	end

	logic [7:0]         staging_low_byte;
	logic [7:0]         staging_high_byte;
	logic [7:0]         snapshot_low_byte;
	logic [7:0]         snapshot_high_byte;
	logic               count_snapshot_hold;
	logic               wr_second;
	logic               rd_second;
	logic               load_now;
	logic [COUNT_W-1:0] next_count;
	logic [2:0]         mode_bits;

	assign mode_bits = setup_byte[`MODE_MSB:`MODE_LSB];

	// --------------------------------------------------------------
	// Programming
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			format <= timer_port_pkg::FORMAT_LOW;
			mode   <= timer_port_pkg::WAVE_MODE0;
			bcd    <= 1'b0;
		end else if (ce && setup_wr) begin
			format <= timer_port_pkg::byte_format_t'(setup_byte[`FMT_MSB:`FMT_LSB]);
			bcd    <= setup_byte[`BCD_BIT];
			// High mode bit is ignored for modes 2 and 3
			if (mode_bits[1])
				mode <= mode_bits[0] ? timer_port_pkg::WAVE_MODE3 : timer_port_pkg::WAVE_MODE2;
			else if (mode_bits[2])
				mode <= mode_bits[0] ? timer_port_pkg::WAVE_MODE5 : timer_port_pkg::WAVE_MODE4;
			else
				mode <= mode_bits[0] ? timer_port_pkg::WAVE_MODE1 : timer_port_pkg::WAVE_MODE0;
		end
	end

	// --------------------------------------------------------------
	// Count writes
	// --------------------------------------------------------------
	always_comb begin
		load_now = 1'b0;
		if (data_wr)
			load_now = (format != timer_port_pkg::FORMAT_BOTH) || wr_second;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			staging_low_byte  <= 8'h00;
			staging_high_byte <= 8'h00;
			wr_second         <= 1'b0;
			loaded            <= 1'b0;
		end else if (ce) begin
			loaded <= load_now;
			if (setup_wr) begin
				staging_low_byte  <= 8'h00;
				staging_high_byte <= 8'h00;
				wr_second         <= 1'b0;
			end else if (data_wr) begin
				unique case (format)
					timer_port_pkg::FORMAT_HIGH: staging_high_byte <= wr_byte;
					timer_port_pkg::FORMAT_BOTH: begin
						if (wr_second)
							staging_high_byte <= wr_byte;
						else
							staging_low_byte <= wr_byte;
						wr_second <= ~wr_second;
					end
					default: staging_low_byte <= wr_byte;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Counting element, binary or four decades
	// --------------------------------------------------------------
	function automatic logic [15:0] bcd_dec(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		for (int i = 0; i < 4; i++) begin
			if (r[i*4 +: 4] != 4'h0) begin
				r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
				break;
			end
			r[i*4 +: 4] = 4'h9;
		end
		return r;
	endfunction : bcd_dec

	always_comb begin
		next_count = count_value;
		if (load_now)
			next_count = (format == timer_port_pkg::FORMAT_LOW) ? {8'h00, wr_byte} :
				(format == timer_port_pkg::FORMAT_HIGH) ? {wr_byte, 8'h00} :
				{wr_byte, staging_low_byte};
		else if (count_tick)
			next_count = bcd ? bcd_dec(count_value) : count_value - 16'h0001;
	end

	// Counting runs on regardless of any held snapshot
	always_ff @(posedge clk) begin
		if (rst)
			count_value <= 16'h0000;
		else if (ce)
			count_value <= next_count;
	end

	// --------------------------------------------------------------
	// Output latch and read sequencing
	// --------------------------------------------------------------
	logic read_done;
	assign read_done = data_rd && ((format != timer_port_pkg::FORMAT_BOTH) || rd_second);

	always_ff @(posedge clk) begin
		if (rst) begin
			count_snapshot_hold <= 1'b0;
			snapshot_low_byte   <= 8'h00;
			snapshot_high_byte  <= 8'h00;
			rd_second           <= 1'b0;
		end else if (ce) begin
			if (setup_wr) begin
				count_snapshot_hold <= 1'b0;
				rd_second           <= 1'b0;
			end else begin
				if (data_rd && format == timer_port_pkg::FORMAT_BOTH)
					rd_second <= ~rd_second;
				if (latch_cmd && !count_snapshot_hold)
					count_snapshot_hold <= 1'b1;
				else if (read_done)
					count_snapshot_hold <= 1'b0;
			end
			if (!count_snapshot_hold && !(latch_cmd && !setup_wr)) begin
				snapshot_low_byte  <= count_value[7:0];
				snapshot_high_byte <= count_value[15:8];
			end else if (latch_cmd && !count_snapshot_hold) begin
				snapshot_low_byte  <= count_value[7:0];
				snapshot_high_byte <= count_value[15:8];
			end
		end
	end

	// Read path sees the latch while held, else the live count
	always_comb begin
		logic [15:0] src;
		src = count_snapshot_hold ? {snapshot_high_byte, snapshot_low_byte} : count_value;
		unique case (format)
			timer_port_pkg::FORMAT_HIGH: rd_byte = src[15:8];
			timer_port_pkg::FORMAT_BOTH: rd_byte = rd_second ? src[15:8] : src[7:0];
			default: rd_byte = src[7:0];
		endcase
	end
endmodule : count_channel
`default_nettype wire

// File: hdl/interval_timer_program_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_port_map.svh"

// How it works
// - No power-up programming needed; reset leaves each channel in low-byte format, mode 0, binary counting.
// - Control words go to port 3 and name their own channel.
// - Count bytes go to the channel's own port, laid out per its format.
// - Bits 7:6 pick channel 0, 1 or 2; 3 is read-back.
// - Bits 5:4 give latch, low only, high only, or low then high.
// - Mode bits decode to six modes; high bit ignored for modes 2 and 3.
// - Bit 0 picks binary or four-decade decimal counting.
// - A new count may come anytime without touching the stored mode.
// - Format 00 on port 3 is a latch command; low bits ignored.
// - Latch freezes the snapshot until read or reprogrammed.
// - Each channel holds its own snapshot state.
// - Latching leaves setup alone and counting continues.
// - A latch to an unread snapshot is ignored.
// - Two-byte byte position survives other accesses.
// - Read and write byte order are tracked separately per channel.
// - Setup clears both staging bytes.
// - Port 3 reads do nothing and leave the bus undriven.
// - Strobes count only while chip select is low, except a read ended by chip select rising.
module interval_timer_program_port #(
	parameter int CHANNELS = 3
) (
	// System
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        CE,
	// Processor bus
	input  wire logic        CS_N,
	input  wire logic        RD_N,
	input  wire logic        WR_N,
	input  wire logic        PORT_SELECT_HI,
	input  wire logic        PORT_SELECT_LO,
	input  wire logic [7:0]  DATA_IN,
	output logic      [7:0]  DATA_OUT,
	output logic             DATA_OE,
	// Count clocks and gates
	input  wire logic [2:0]  COUNT_CLK,
	input  wire logic [2:0]  GATE,
	// Channel state
	output logic      [47:0] COUNT_VALUE,
	output logic      [2:0]  COUNT_LOADED
);
	if (CHANNELS != 3) begin : g_bad_channels
		$error("two select bits serve exactly three channels");
	end

	// ------------------------------------------------------------------
	// Strobe decode
	// ------------------------------------------------------------------
	logic [1:0] port_sel;
	logic       rd_level;
	logic       wr_level;
	logic       rd_prev;
	logic       wr_prev;
	logic       rd_pulse;
	logic       wr_pulse;
	logic [2:0] clk_prev;

	assign port_sel = {PORT_SELECT_HI, PORT_SELECT_LO};
	assign rd_level = !CS_N && !RD_N;
	assign wr_level = !CS_N && !WR_N;

	// Act once per strobe, at its trailing edge where the data is settled
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rd_prev  <= 1'b0;
			wr_prev  <= 1'b0;
			clk_prev <= 3'h0;
		end else if (CE) begin
			rd_prev  <= rd_level;
			wr_prev  <= wr_level;
			clk_prev <= COUNT_CLK;
		end
	end

	assign rd_pulse = rd_prev && !rd_level;
	assign wr_pulse = wr_prev && !wr_level && !CS_N;

	logic       setup_sel;
	logic [1:0] channel_pick;
	logic [1:0] byte_format;

	assign setup_sel    = wr_pulse && port_sel == `SETUP_PORT_SEL;
	assign channel_pick = DATA_IN[`SEL_MSB:`SEL_LSB];
	assign byte_format  = DATA_IN[`FMT_MSB:`FMT_LSB];

	// ------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------
	logic [7:0] rd_byte [3];
	logic [2:0] ch_setup;
	logic [2:0] ch_latch;
	logic [2:0] ch_wr;
	logic [2:0] ch_rd;
	logic [2:0] ch_tick;
	logic [15:0] ch_count [3];
	logic [2:0] ch_loaded;

	for (genvar i = 0; i < 3; i++) begin : g_ch
		// Read-back selector 11 never matches a channel index
		assign ch_setup[i] = setup_sel && channel_pick == 2'(i) && byte_format != `FMT_LATCH;
		assign ch_latch[i] = setup_sel && channel_pick == 2'(i) && byte_format == `FMT_LATCH;
		assign ch_wr[i]    = wr_pulse && port_sel == 2'(i);
		assign ch_rd[i]    = rd_pulse && port_sel == 2'(i);
		assign ch_tick[i]  = COUNT_CLK[i] && !clk_prev[i] && GATE[i];

		count_channel #(.COUNT_W(16)) u_ch (
			.clk         (CLK_SYS),
			.rst         (RST),
			.ce          (CE),
			.setup_wr    (ch_setup[i]),
			.latch_cmd   (ch_latch[i]),
			.setup_byte  (DATA_IN),
			.data_wr     (ch_wr[i]),
			.data_rd     (ch_rd[i]),
			.wr_byte     (DATA_IN),
			.count_tick  (ch_tick[i]),
			.rd_byte     (rd_byte[i]),
			.count_value (ch_count[i]),
			.format      (),
			.mode        (),
			.bcd         (),
			.loaded      (ch_loaded[i])
		);
	end

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			DATA_OUT     <= 8'h00;
			DATA_OE      <= 1'b0;
			COUNT_VALUE  <= 48'h000000000000;
			COUNT_LOADED <= 3'h0;
		end else if (CE) begin
			DATA_OE      <= rd_level && port_sel != `SETUP_PORT_SEL;
			DATA_OUT     <= (port_sel != `SETUP_PORT_SEL) ? rd_byte[port_sel] : 8'h00;
			COUNT_VALUE  <= {ch_count[2], ch_count[1], ch_count[0]};
			COUNT_LOADED <= ch_loaded;
		end
	end
endmodule : interval_timer_program_port
`default_nettype wire

// File: tb/timer_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module timer_port_checker (
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        CS_N,
	input wire logic        RD_N,
	input wire logic        WR_N,
	input wire logic        PORT_SELECT_HI,
	input wire logic        PORT_SELECT_LO,
	input wire logic        DATA_OE,
	input wire logic [2:0]  COUNT_CLK,
	input wire logic [2:0]  GATE,
	input wire logic [47:0] COUNT_VALUE,
	input wire logic [2:0]  COUNT_LOADED
);
	logic       rd_chan;
	logic [2:0] wr_age;
	logic [2:0] ck_age;
	assign rd_chan = !CS_N && !RD_N && !(PORT_SELECT_HI && PORT_SELECT_LO);
	// Ages saturate at 7; reset counts as recent so nothing fires early
	always_ff @(posedge CLK_SYS) begin
		if (RST || (!CS_N && !WR_N)) wr_age <= 3'h0;
		else if (wr_age != 3'h7) wr_age <= wr_age + 3'h1;
	end
	always_ff @(posedge CLK_SYS) begin
		if (RST || (COUNT_CLK[0] && GATE[0])) ck_age <= 3'h0;
		else if (ck_age != 3'h7) ck_age <= ck_age + 3'h1;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	AST_OE_CAUSE: assert property (DATA_OE |-> $past(rd_chan))
		else $error("bus driven without a channel read");
	AST_SETUP_READ_QUIET: assert property (!CS_N && !RD_N && PORT_SELECT_HI && PORT_SELECT_LO |=> !DATA_OE)
		else $error("setup port read drove the bus");
	AST_DESELECT_QUIET: assert property (CS_N |=> !DATA_OE)
		else $error("bus driven while deselected");
	AST_READ_ANSWER: assert property (rd_chan ##1 rd_chan |-> DATA_OE)
		else $error("channel read not answered");
	AST_LOAD_AFTER_WRITE: assert property (|COUNT_LOADED |-> wr_age <= 3'h4)
		else $error("load without a write");
	AST_LOAD_PULSE: assert property (|COUNT_LOADED |=> COUNT_LOADED == 3'h0)
		else $error("load pulse too long");
	AST_COUNT_CAUSE: assert property ($changed(COUNT_VALUE[15:0]) |-> wr_age <= 3'h5 || ck_age <= 3'h5)
		else $error("count moved without cause");
	AST_RESET_CLEAR: assert property ($fell(RST) |-> COUNT_VALUE == 48'h0 && COUNT_LOADED == 3'h0 && !DATA_OE)
		else $error("outputs not clear after reset");
endmodule : timer_port_checker
bind interval_timer_program_port timer_port_checker chk (.CLK_SYS(CLK_SYS), .RST(RST), .CS_N(CS_N), .RD_N(RD_N),
	.WR_N(WR_N), .PORT_SELECT_HI(PORT_SELECT_HI), .PORT_SELECT_LO(PORT_SELECT_LO), .DATA_OE(DATA_OE),
	.COUNT_CLK(COUNT_CLK), .GATE(GATE), .COUNT_VALUE(COUNT_VALUE), .COUNT_LOADED(COUNT_LOADED));
`default_nettype wire

// File: tb/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the 8-bit bus; callers keep setup-before-count and byte order
module cpu_bus_model (
	input  wire logic       clk,
	input  wire logic [7:0] din,
	input  wire logic       oe,
	output logic            cs_n = 1'b1,
	output logic            rd_n = 1'b1,
	output logic            wr_n = 1'b1,
	output logic [1:0]      a = 2'h0,
	output logic [7:0]      dout = 8'hFF
);
	task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic n = 1'b0);
		@(posedge clk) #1;
		cs_n = n;
		wr_n = 1'b0;
		a = s;
		dout = d;
		@(posedge clk) #1;
		wr_n = 1'b1;
		@(posedge clk) #1;
		cs_n = 1'b1;
		dout = ~d; // Released bus must not show a stale byte
	endtask : wr
	task automatic rd(input logic [1:0] s, output logic [7:0] d, output logic e, input logic n = 1'b0);
		@(posedge clk) #1;
		cs_n = n;
		rd_n = 1'b0;
		a = s;
		repeat (2) @(posedge clk);
		#1;
		d = din;
		e = oe;
		rd_n = 1'b1;
		@(posedge clk) #1;
		cs_n = 1'b1;
	endtask : rd
endmodule : cpu_bus_model
`default_nettype wire

// File: tb/interval_timer_program_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer_program_port_tb;
	logic        CLK_SYS;
	logic        RST;
	logic        ce;
	logic [2:0]  ld;
	int          loads;
	logic [2:0]  COUNT_CLK;
	logic [2:0]  GATE;
	logic        cs_n, rd_n, wr_n, oe;
	logic [1:0]  a;
	logic [7:0]  din, dout;
	logic [47:0] cnt;
	int          errors;
	int          check_count;

	cpu_bus_model host (.clk(CLK_SYS), .din(dout), .oe(oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a(a), .dout(din));
	interval_timer_program_port dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(ce), .CS_N(cs_n), .RD_N(rd_n),
		.WR_N(wr_n), .PORT_SELECT_HI(a[1]), .PORT_SELECT_LO(a[0]), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OE(oe), .COUNT_CLK(COUNT_CLK), .GATE(GATE), .COUNT_VALUE(cnt), .COUNT_LOADED(ld));

	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end

	// Each complete count gives exactly one one-cycle load pulse
	always @(posedge CLK_SYS) begin
		if (|ld)
			loads++;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic setup(input logic [1:0] c, input logic [1:0] f);
		host.wr(2'h3, {c, f, 4'h0});
	endtask : setup
	task automatic cv(input int c, input logic [15:0] e);
		repeat (2) @(posedge CLK_SYS);
		#1;
		chk(cnt[c*16 +: 16], e);
	endtask : cv
	task automatic rb(input logic [1:0] c, input logic [7:0] e);
		logic [7:0] d;
		logic       s;
		host.rd(c, d, s);
		chk({s, 7'h0, d}, {1'b1, 7'h0, e});
	endtask : rb
	task automatic no_drive(input logic [1:0] c, input logic n);
		logic [7:0] d;
		logic       s;
		host.rd(c, d, s, n);
		chk({15'h0, s}, 16'h0);
	endtask : no_drive
	// Count clock stands still between pulses
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge CLK_SYS) #1;
			COUNT_CLK = 3'h7;
			repeat (2) @(posedge CLK_SYS);
			#1;
			COUNT_CLK = 3'h0;
			@(posedge CLK_SYS);
		end
	endtask : pulse

	task automatic t_formats();
		for (int c = 0; c < 3; c++) begin
			setup(2'(c), 2'h1);
			host.wr(2'(c), 8'h5A);
			cv(c, 16'h005A);
			rb(2'(c), 8'h5A);
			setup(2'(c), 2'h2);
			host.wr(2'(c), 8'hA5);
			cv(c, 16'hA500);
			rb(2'(c), 8'hA5);
			setup(2'(c), 2'h3);
			host.wr(2'(c), 8'h34);
			cv(c, 16'hA500);
			host.wr(2'(c), 8'h12 + 8'(c));
			cv(c, {8'h12 + 8'(c), 8'h34});
			rb(2'(c), 8'h34);
			rb(2'(c), 8'h12 + 8'(c));
		end
		chk(16'(loads), 16'h0009);
		$display("test formats done");
	endtask : t_formats
	task automatic t_latch();
		GATE = 3'h3;
		pulse(3);
		host.wr(2'h3, 8'h0F);
		pulse(2);
		cv(0, 16'h122F);
		host.wr(2'h3, 8'h40);
		host.wr(2'h3, 8'h05);
		pulse(1);
		#1;
		GATE = 3'h0; // Counting stopped before plain reads
		rb(2'h0, 8'h31);
		rb(2'h0, 8'h12);
		rb(2'h0, 8'h2E);
		rb(2'h0, 8'h12);
		rb(2'h1, 8'h2F);
		rb(2'h1, 8'h13);
		rb(2'h1, 8'h2E);
		rb(2'h1, 8'h13);
		$display("test latch done");
	endtask : t_latch
	task automatic t_order();
		setup(2'h2, 2'h3);
		host.wr(2'h2, 8'hCD);
		host.wr(2'h2, 8'hAB);
		rb(2'h2, 8'hCD);
		host.wr(2'h2, 8'h11);
		setup(2'h0, 2'h1);
		rb(2'h2, 8'hAB);
		host.wr(2'h2, 8'h22);
		cv(2, 16'h2211);
		host.wr(2'h2, 8'h55);
		host.wr(2'h3, 8'h80);
		setup(2'h2, 2'h3);
		host.wr(2'h2, 8'h01);
		host.wr(2'h2, 8'h00);
		cv(2, 16'h0001);
		rb(2'h2, 8'h01);
		rb(2'h2, 8'h00);
		$display("test order done");
	endtask : t_order
	task automatic t_refuse();
		host.wr(2'h0, 8'hEE, 1'b1);
		cv(0, 16'h122E);
		no_drive(2'h0, 1'b1);
		no_drive(2'h3, 1'b0);
		host.wr(2'h3, 8'hF1);
		host.wr(2'h0, 8'h44);
		cv(0, 16'h0044);
		$display("test refuse done");
	endtask : t_refuse
	// Decimal count of 1000 must step to 0999, not 0FFF
	task automatic t_bcd();
		host.wr(2'h3, 8'h71);
		host.wr(2'h1, 8'h00);
		host.wr(2'h1, 8'h10);
		GATE = 3'h2;
		pulse(1);
		cv(1, 16'h0999);
		GATE = 3'h0;
		$display("test bcd done");
	endtask : t_bcd
	// A frozen block drops the strobe; a second reset restores defaults
	task automatic t_freeze();
		ce = 1'b0;
		host.wr(2'h0, 8'h77);
		cv(0, 16'h0044);
		ce = 1'b1;
		cv(0, 16'h0044);
		RST = 1'b1;
		repeat (2) @(posedge CLK_SYS);
		#1;
		RST = 1'b0;
		cv(0, 16'h0000);
		host.wr(2'h0, 8'h66);
		cv(0, 16'h0066);
		$display("test freeze done");
	endtask : t_freeze

	initial begin
		errors = 0;
		check_count = 0;
		loads = 0;
		ce = 1'b1;
		RST = 1'b1;
		COUNT_CLK = 3'h0;
		GATE = 3'h0;
		repeat (12) @(posedge CLK_SYS);
		#1;
		RST = 1'b0;
		cv(0, 16'h0000);
		t_formats();
		t_latch();
		t_order();
		t_refuse();
		t_bcd();
		t_freeze();
		tally_and_finish();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		errors++;
		tally_and_finish();
	end
endmodule : interval_timer_program_port_tb
`default_nettype wire
